// ==== sdp_port.sv ====
`default_nettype none
`include "sdp_params.svh"
module sdp_port #(
    parameter logic [15:0] IO_BASE   = `SDP_DEF_IO_BASE,
    parameter logic [3:0]  ARB_LEVEL = `SDP_DEF_ARB_LEVEL,
    parameter int          PORT_BITS = 32
) (
    input  wire logic        sys_clk,
    input  wire logic        resetn,
    input  wire logic        cmd_n,
    input  wire logic        address_latch_strobe_n,
    input  wire logic        stream_strobe_n,
    input  wire logic        status_line_zero_n,
    input  wire logic        status_line_one_n,
    input  wire logic        mem_io,
    input  wire logic [3:0]  arb_bus,
    input  wire logic [31:0] addr_in,
    input  wire logic [3:0]  byte_enables_n,
    input  wire logic [31:0] data_in,
    input  wire logic        terminal_count_n,
    input  wire logic        sel_by_io_addr,
    input  wire logic        wide_mode,
    input  wire logic        dma_mode,
    input  wire logic        src_valid,
    input  wire logic [63:0] src_data,
    input  wire logic        sink_ready,
    output logic             src_taken,
    output logic [63:0]      sink_data,
    output logic             sink_valid,
    output logic             sink_odd,
    output logic [31:0]      data_out,
    output logic             data_oe_n,
    output logic [31:0]      addr_out,
    output logic             addr_oe_n,
    output logic             streaming_ready_n,
    output logic             wide_stream_ready_n,
    output logic             card_channel_ready,
    output logic             card_selected_feedback_n,
    output logic             sel_active
);
    initial begin
        if (PORT_BITS != 16 && PORT_BITS != 32)
            $error("PORT_BITS must be 16 or 32");
    end

    localparam int HOLD_CYC = `SDP_CMD_HOLD_CYC;
    localparam logic [15:0] ALIGN_MASK =
        (PORT_BITS == 16) ? 16'h0001 : 16'h0003;

    logic [7:0] raw, syn;
    assign raw = {cmd_n, address_latch_strobe_n, stream_strobe_n,
                  status_line_zero_n, status_line_one_n, mem_io,
                  terminal_count_n, 1'b0};
    // strobes are asynchronous to sys_clk
    sdp_sync #(.W(8)) u_sync (
        .sys_clk  (sys_clk),
        .resetn   (resetn),
        .async_in (raw),
        .sync_out (syn)
    );
    logic cmd_s, adl_s, ss_s, s0_s, s1_s, mio_s, tc_s;
    assign {cmd_s, adl_s, ss_s, s0_s, s1_s, mio_s, tc_s} = syn[7:1];

    logic ss_q, cmd_q, adl_q;
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            ss_q  <= 1'b1;
            cmd_q <= 1'b1;
            adl_q <= 1'b1;
        end else begin
            ss_q  <= ss_s;
            cmd_q <= cmd_s;
            adl_q <= adl_s;
        end
    end
    wire ss_fall  = ss_q & ~ss_s;
    wire cmd_rise = ~cmd_q & cmd_s;
    wire adl_fall = adl_q & ~adl_s;

    function automatic logic aligned(input logic [15:0] a);
        aligned = (a & ALIGN_MASK) == 16'h0000;
    endfunction

    // one method only, chosen by a single bit
    wire io_cycle  = ~mio_s;
    wire stat_xor  = s0_s ^ s1_s;
    wire sel_level = (arb_bus == ARB_LEVEL) & stat_xor & io_cycle;
    wire sel_addr  = (addr_in[15:0] == IO_BASE) & ~(s0_s & s1_s)
                     & io_cycle & aligned(addr_in[15:0]);
    wire sel_now   = sel_by_io_addr ? sel_addr : sel_level;
    wire is_read   = ~s1_s & s0_s;   // s1 low, s0 high: read from slave
    wire stall     = is_read ? ~src_valid : (sink_valid & ~sink_ready);

    sdp_pkg::sdp_state_t state, next_state;
    logic decoded;
    logic [31:0] addr_hold;
    logic [3:0]  be_hold;

    always_comb begin
        next_state = state;
        case (state)
            sdp_pkg::SDP_IDLE:
                if (decoded && !cmd_s)
                    next_state = stall ? sdp_pkg::SDP_DEFER
                                       : sdp_pkg::SDP_STREAM;
            sdp_pkg::SDP_DEFER:
                if (cmd_s) next_state = sdp_pkg::SDP_IDLE;
                else if (!stall) next_state = sdp_pkg::SDP_STREAM;
            sdp_pkg::SDP_STREAM:
                if (cmd_s) next_state = sdp_pkg::SDP_IDLE;
            default:
                next_state = sdp_pkg::SDP_IDLE;
        endcase
    end

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            state     <= sdp_pkg::SDP_IDLE;
            decoded   <= 1'b0;
            addr_hold <= 32'h00000000;
            be_hold   <= 4'hf;
        end else begin
            state <= next_state;
            if (adl_fall) begin
                decoded   <= sel_now;
                addr_hold <= addr_in;
                be_hold   <= byte_enables_n;
            end else if (cmd_rise) begin
                decoded <= 1'b0;
            end
        end
    end

    wire in_cycle = (state != sdp_pkg::SDP_IDLE);
    wire wide     = wide_mode & decoded;
    // pacing only before SDP_STREAM is entered in 64-bit mode
    wire pace_ok  = !(wide && state == sdp_pkg::SDP_STREAM);
    wire want_rdy = !(in_cycle && stall && pace_ok);
    // an odd count shows as a partial byte-enable set
    wire odd_be   = (be_hold != 4'h0) && (be_hold != 4'hf);

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            card_channel_ready       <= 1'b1;
            streaming_ready_n        <= 1'b1;
            wide_stream_ready_n      <= 1'b1;
            card_selected_feedback_n <= 1'b1;
            sel_active               <= 1'b0;
            data_oe_n                <= 1'b1;
            addr_oe_n                <= 1'b1;
            data_out                 <= 32'h00000000;
            addr_out                 <= 32'h00000000;
            src_taken                <= 1'b0;
        end else begin
            src_taken <= 1'b0;
            // slow source or sink stretches the cycle
            card_channel_ready <= want_rdy | ~decoded;
            // held asserted whenever ready is low
            streaming_ready_n   <= ~decoded | (cmd_s & want_rdy);
            wide_stream_ready_n <= ~wide | cmd_s;
            card_selected_feedback_n <= ~(decoded & io_cycle & dma_mode);
            sel_active <= decoded;
            data_oe_n  <= ~(decoded & is_read & ~cmd_s);
            // upper half on the address lines after float
            addr_oe_n  <= ~(wide & is_read & ~cmd_s
                            & (byte_enables_n == 4'hf));
            if (decoded && is_read && (ss_fall || adl_fall) && src_valid) begin
                data_out  <= src_data[31:0];
                addr_out  <= src_data[63:32];
                src_taken <= 1'b1;
            end
        end
    end

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            sink_data  <= 64'h0;
            sink_valid <= 1'b0;
            sink_odd   <= 1'b0;
        end else begin
            if (sink_valid && sink_ready) sink_valid <= 1'b0;
            // store on strobe fall, or on command trailing edge
            if (decoded && !is_read && (ss_fall || cmd_rise)
                && !(sink_valid && !sink_ready)) begin
                sink_data  <= {addr_in, data_in};
                sink_valid <= 1'b1;
                sink_odd   <= odd_be;
            end
        end
    end

    // guards on the registered answers; all one clock domain
    sequence s_adl_edge;
        adl_fall;
    endsequence
    sequence s_store_edge;
        decoded && !is_read && cmd_rise && !(sink_valid && !sink_ready);
    endsequence
    sequence s_send_edge;
        decoded && is_read && ss_fall && src_valid;
    endsequence

    property p_decode_latch;
        @(posedge sys_clk) disable iff (!resetn)
        s_adl_edge |=> (decoded == $past(sel_now));
    endproperty
    a_decode_latch: assert property (p_decode_latch)
        else $error("decode not latched at address strobe");

    property p_ready_after_decode;
        @(posedge sys_clk) disable iff (!resetn)
        !streaming_ready_n |-> $past(decoded);
    endproperty
    a_ready_after_decode: assert property (p_ready_after_decode)
        else $error("streaming ready without decode");

    property p_ready_held;
        @(posedge sys_clk) disable iff (!resetn)
        !card_channel_ready |-> !streaming_ready_n;
    endproperty
    a_ready_held: assert property (p_ready_held)
        else $error("streaming ready dropped while not ready");

    property p_feedback;
        @(posedge sys_clk) disable iff (!resetn)
        (decoded && io_cycle && dma_mode) |=> !card_selected_feedback_n;
    endproperty
    a_feedback: assert property (p_feedback)
        else $error("no feedback during dma io part");

    property p_store_on_cmd;
        @(posedge sys_clk) disable iff (!resetn)
        s_store_edge |=> sink_valid && (sink_data == $past({addr_in, data_in}));
    endproperty
    a_store_on_cmd: assert property (p_store_on_cmd)
        else $error("write data not stored at command end");

    property p_send_on_fall;
        @(posedge sys_clk) disable iff (!resetn)
        s_send_edge |=> src_taken && (data_out == $past(src_data[31:0]));
    endproperty
    a_send_on_fall: assert property (p_send_on_fall)
        else $error("read data not driven at strobe fall");

    property p_no_pace_wide;
        @(posedge sys_clk) disable iff (!resetn)
        (wide && state == sdp_pkg::SDP_STREAM) |=> card_channel_ready;
    endproperty
    a_no_pace_wide: assert property (p_no_pace_wide)
        else $error("pacing during wide streaming");
endmodule
`default_nettype wire

// ==== sdp_params.svh ====
`ifndef SDP_PARAMS_SVH
`define SDP_PARAMS_SVH
// channel rules and internal clock
`define SDP_CLK_MHZ          25
`define SDP_XFER_LIMIT_NS    7800
`define SDP_XFER_LIMIT_CYC   ((`SDP_XFER_LIMIT_NS * `SDP_CLK_MHZ) / 1000)
`define SDP_CMD_HOLD_NS      100
`define SDP_CMD_HOLD_CYC     ((`SDP_CMD_HOLD_NS * `SDP_CLK_MHZ + 999) / 1000)
`define SDP_IO_ALT_HI        16'hfffc
`define SDP_IO_ALT_LO        16'h0000
`define SDP_DEF_IO_BASE      16'h0100
`define SDP_DEF_ARB_LEVEL    4'h3
`endif

// ==== sdp_pkg.sv ====
`default_nettype none
package sdp_pkg;
    typedef enum logic [1:0] {
        SDP_W16,
        SDP_W32,
        SDP_W64
    } sdp_width_t;
    typedef enum {
        SDP_IDLE,
        SDP_DEFER,
        SDP_STREAM,
        SDP_BASIC,
        SDP_DONE
    } sdp_state_t;
endpackage
`default_nettype wire

// ==== sdp_sync.sv ====
`default_nettype none
module sdp_sync #(
    parameter int W = 1
) (
    input  wire logic         sys_clk,
    input  wire logic         resetn,
    input  wire logic [W-1:0] async_in,
    output var  logic [W-1:0] sync_out
);
    logic [W-1:0] meta;
    // first stage is read only by the second
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            meta     <= '0;
            sync_out <= '0;
        end else begin
            meta     <= async_in;
            sync_out <= meta;
        end
    end
endmodule
`default_nettype wire

// ==== sdp_master_model.sv ====
`default_nettype none
module sdp_master_model (
    input  wire logic        sys_clk,
    output var  logic        cmd_n,
    output var  logic        address_latch_strobe_n,
    output var  logic        stream_strobe_n,
    output var  logic        status_line_zero_n,
    output var  logic        status_line_one_n,
    output var  logic        mem_io,
    output var  logic [31:0] data_in
);
    timeunit 1ns;
    timeprecision 1ns;
    initial begin
        {cmd_n, address_latch_strobe_n, stream_strobe_n} = 3'h7;
        {status_line_one_n, status_line_zero_n, mem_io} = 3'h7;
        data_in = 32'h5a5a5a5a;
    end
    task automatic wt(input int n);
        repeat (n) @(posedge sys_clk);
    endtask
    // strobe stands high outside frames
    task automatic open_frame(input logic [1:0] st, input logic mio);
        {status_line_one_n, status_line_zero_n} <= st;
        mem_io <= mio;
        address_latch_strobe_n <= 1'b0;
        wt(4);
        address_latch_strobe_n <= 1'b1;
        cmd_n <= 1'b0;
        wt(8);
    endtask
    task automatic stream(input logic [31:0] w [3]);
        for (int i = 0; i < 3; i++) begin
            data_in <= w[i];
            wt(1);
            stream_strobe_n <= 1'b0; // after command
            if (i == 2) begin
                {status_line_one_n, status_line_zero_n} <= 2'h3;
            end
            wt(4);
            stream_strobe_n <= 1'b1; // 320 ns period
            wt(3);
        end
        wt(1);
        cmd_n <= 1'b1; // 320 ns past last fall
        // held past the hold time: the slave syncs cmd first
        wt(4);
        data_in <= ~data_in;
        mem_io <= 1'b1;
        wt(4);
    endtask
endmodule
`default_nettype wire

// ==== testbench.sv ====
`default_nettype none
`include "sdp_params.svh"
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    logic        sys_clk, resetn, sel_by_io_addr, dma_mode, src_valid;
    logic [3:0]  arb_bus;
    logic [31:0] addr_in;
    logic [63:0] src_data, sink_data;
    wire logic   cmd_n, address_latch_strobe_n, stream_strobe_n;
    wire logic   status_line_zero_n, status_line_one_n, mem_io;
    wire logic [31:0] data_in;
    logic        sink_valid, streaming_ready_n, wide_stream_ready_n;
    logic        card_selected_feedback_n, sel_active;
    int          num_errors, comparisons;
    logic [31:0] got_q [$];
    logic [31:0] exp_q [$];
    sdp_master_model m_u (.sys_clk, .cmd_n, .address_latch_strobe_n,
        .stream_strobe_n, .status_line_zero_n, .status_line_one_n,
        .mem_io, .data_in);
    sdp_port dut_u (.sys_clk, .resetn, .cmd_n, .address_latch_strobe_n,
        .stream_strobe_n, .status_line_zero_n, .status_line_one_n,
        .mem_io, .arb_bus, .addr_in, .byte_enables_n(4'h0), .data_in,
        .terminal_count_n(1'b1), .sel_by_io_addr, .wide_mode(1'b0),
        .dma_mode, .src_valid, .src_data, .sink_ready(1'b1),
        .src_taken(), .sink_data, .sink_valid, .sink_odd(), .data_out(),
        .data_oe_n(), .addr_out(), .addr_oe_n(), .streaming_ready_n,
        .wide_stream_ready_n, .card_channel_ready(),
        .card_selected_feedback_n, .sel_active);
    task automatic check(input string nm, input logic [63:0] seen, exp);
        comparisons++;
        if (seen !== exp) begin
            num_errors++;
            $display("mismatch %s exp %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic results;
        if (num_errors == 0 && comparisons > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    task automatic idle_check;
        check("sel", 64'(sel_active), 64'h0);
        check("fbk", 64'(card_selected_feedback_n), 64'h1);
        check("sdr", 64'(streaming_ready_n), 64'h1);
    endtask
    always @(posedge sys_clk) begin
        if (sink_valid === 1'b1) begin
            got_q.push_back(sink_data[31:0]);
        end
    end
    initial begin
        sys_clk = 1'b0;
        forever #20 sys_clk = ~sys_clk;
    end
    initial begin
        #200us;
        num_errors++;
        results();
    end
    initial begin
        logic [31:0] w [3];
        logic [1:0]  st;
        logic        m;
        {resetn, sel_by_io_addr, dma_mode, src_valid} = 4'h0;
        arb_bus = 4'h0;
        addr_in = 32'h0;
        src_data = 64'h0;
        void'($urandom(32'hc003ac28));
        repeat (12) @(posedge sys_clk);
        resetn <= 1'b1;
        repeat (4) @(posedge sys_clk);
        idle_check();
        for (int i = 0; i < 16; i++) begin
            st = (i < 4 || i[0]) ? 2'b10 : 2'($urandom);
            sel_by_io_addr <= 1'(i >> 1);
            dma_mode <= 1'($urandom);
            src_valid <= 1'($urandom);
            src_data <= {$urandom, $urandom};
            arb_bus <= (i < 2 || $urandom_range(3) != 0)
                ? `SDP_DEF_ARB_LEVEL : 4'($urandom);
            addr_in <= (i < 4 || $urandom_range(3) != 0)
                ? {16'h0, `SDP_DEF_IO_BASE} : $urandom;
            foreach (w[k]) w[k] = $urandom;
            m_u.open_frame(st, 1'(i % 5 == 4));
            // level, status xor and io cycle; one method only
            // address method takes any active status, level method the xor
            m = !mem_io && (sel_by_io_addr
                ? (st != 2'b11 && addr_in[15:0] == `SDP_DEF_IO_BASE)
                : ((st == 2'b10 || st == 2'b01)
                   && arb_bus == `SDP_DEF_ARB_LEVEL));
            check("sel", 64'(sel_active), 64'(m));
            check("fbk", 64'(card_selected_feedback_n), 64'(!(m && dma_mode)));
            check("sdr", 64'(streaming_ready_n), 64'(!m));
            check("wide_stream_ready", 64'(wide_stream_ready_n), 64'h1);
            if (m && st == 2'b10) begin
                exp_q.push_back(w[2]);
            end
            m_u.stream(w);
            idle_check();
            if (exp_q.size() > 0) begin
                check("cnt", 64'(got_q.size() > 0), 64'h1);
                check("word", 64'(got_q[$]), 64'(exp_q.pop_front()));
            end else if (!m) begin
                check("cnt", 64'(got_q.size()), 64'h0);
            end
            got_q.delete();
        end
        results();
    end
endmodule
`default_nettype wire
